// ===== rtl/dps_port.sv
// Tool access port front end: telegram receiver, protocol select and guard, TAP feed.
// Assumes the tool drives the port clock pin; it is sampled here, never used as a clock.
// Functional notes
// - Power-on reset starts in two-pin serial mode
// - Protocol changes only on selection telegrams or restart
// - All telegrams need CRC except switch-to-JTAG
// - Guard setting can block switch-to-JTAG telegram
// - Guard 01: protected two-pin, JTAG switch ignored
// - Guard 11: three-pin, JTAG switch still honoured
// - Outside JTAG, TAP mode-select fed zeros
// - Restart acts only on a port clock edge
// - Capture-IR loads instruction shift with 01
// - Shift-IR shifts right, new bit at top
// - Update-IR copies shift register unconditionally
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module dps_port #(
    parameter int IR_WIDTH = 8
) (
    input  wire logic                 ref_clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 debug_port_clock_pin_in,
    input  wire logic                 dbg_data_in,
    output logic                      dbg_data_out,
    output logic                      dbg_data_oe_out,
    input  wire logic                 dbg_aux_in,
    output logic                      dbg_tdo_out,
    output logic                      dbg_tdo_oe_out,
    input  wire logic                 restart_in,
    output dps_pkg::dps_mode_t        protocol_mode_out,
    output logic [1:0]                jtag_switch_guard_mode_out,
    output logic                      telegram_ok_out,
    output logic                      crc_error_out,
    output logic                      tap_in_reset_out,
    output logic [IR_WIDTH-1:0]       jtag_ir_out
);
    import dps_pkg::*;

    localparam int FRAME_BITS = 24;

    if (FRAME_BITS != 24 || IR_WIDTH < 2) begin : g_bad_cfg
        $error("dps_port: unsupported frame or instruction width");
    end

    function automatic logic [7:0] crc8(input logic [15:0] data);
        logic [7:0] c;
        c = `DPS_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ `DPS_CRC_POLY) : {c[6:0], 1'b0};
        end
        crc8 = c;
    endfunction : crc8

    // Pin synchronisers; first stages feed only the second stages
    logic [1:0] clk_sync;
    logic [1:0] data_sync;
    logic [1:0] aux_sync;
    logic       clk_prev;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clk_sync  <= 2'h0;
            data_sync <= 2'h3;
            aux_sync  <= 2'h0;
            clk_prev  <= 1'b0;
        end else begin
            clk_sync  <= {clk_sync[0], debug_port_clock_pin_in};
            data_sync <= {data_sync[0], dbg_data_in};
            aux_sync  <= {aux_sync[0], dbg_aux_in};
            clk_prev  <= clk_sync[1];
        end
    end

    wire logic link_rise = clk_sync[1] & ~clk_prev;
    wire logic link_fall = ~clk_sync[1] & clk_prev;
    wire logic data_bit  = data_sync[1];
    wire logic aux_bit   = aux_sync[1];

    dps_mode_t   mode;
    dps_rx_t     rx_state;
    logic [4:0]  rx_cnt;
    logic [23:0] rx_shift;
    logic [1:0]  guard;
    logic        ack_val;

    // Decode of the frame as it completes on this edge
    wire logic [23:0] next_frame  = {rx_shift[22:0], data_bit};
    wire logic [7:0]  frame_opc   = next_frame[23:16];
    wire logic [7:0]  frame_arg   = next_frame[15:8];
    wire logic        crc_good    = (crc8(next_frame[23:8]) == next_frame[7:0]);
    wire logic        frame_last  = (rx_cnt == `DPS_FRAME_BITS - 5'h1);
    wire logic        frame_done  = (rx_state == DPS_RX_BITS) && link_rise && frame_last;
    wire logic        is_jtag_opc = (frame_opc == `DPS_OPC_JTAG);
    wire logic        guard_block = (guard == `DPS_GUARD_PROTECT);
    wire logic        jtag_take   = frame_done && is_jtag_opc && !guard_block;
    wire logic        guard_take  = frame_done && (frame_opc == `DPS_OPC_GUARD) && crc_good;
    wire logic        three_take  = frame_done && (frame_opc == `DPS_OPC_THREE_PIN) && crc_good;
    wire logic        frame_ok    = jtag_take || guard_take || three_take;
    wire logic        crc_bad     = frame_done && !is_jtag_opc && !crc_good;
    // Restart is sensed only with a port clock edge; a still clock loses it
    wire logic        restart_hit = restart_in && link_rise;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode  <= DPS_MODE_TWO_PIN;
            guard <= `DPS_GUARD_RESET;
        end else if (restart_hit) begin
            mode <= DPS_MODE_TWO_PIN;
        end else if (jtag_take) begin
            mode <= DPS_MODE_JTAG;
        end else if (three_take) begin
            mode <= DPS_MODE_THREE_PIN;
        end else if (guard_take) begin
            guard <= frame_arg[1:0];
            if (frame_arg[1:0] == `DPS_GUARD_THREE_PIN) begin
                mode <= DPS_MODE_THREE_PIN;
            end else if (frame_arg[1:0] == `DPS_GUARD_PROTECT) begin
                mode <= DPS_MODE_TWO_PIN;
            end
        end
    end

    // Telegram receiver: start bit 0, then opcode, argument and CRC, most significant first
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_state <= DPS_RX_IDLE;
            rx_cnt   <= 5'h0;
            rx_shift <= 24'h000000;
            ack_val  <= 1'b0;
        end else if (restart_hit || mode == DPS_MODE_JTAG) begin
            rx_state <= DPS_RX_IDLE;
            rx_cnt   <= 5'h0;
        end else if (link_rise) begin
            case (rx_state)
                DPS_RX_IDLE: begin
                    if (!data_bit) begin
                        rx_state <= DPS_RX_BITS;
                        rx_cnt   <= 5'h0;
                    end
                end
                DPS_RX_BITS: begin
                    rx_shift <= next_frame;
                    rx_cnt   <= rx_cnt + 5'h1;
                    if (frame_last) begin
                        rx_state <= jtag_take ? DPS_RX_IDLE : DPS_RX_ACK;
                        ack_val  <= frame_ok;
                    end
                end
                DPS_RX_ACK: begin
                    rx_state <= DPS_RX_IDLE;
                end
                default: begin
                    rx_state <= DPS_RX_IDLE;
                end
            endcase
        end
    end

    dps_tap_if #(.IR_WIDTH(IR_WIDTH)) tap_bus ();

    assign tap_bus.step     = link_rise;
    assign tap_bus.tck_fall = link_fall;
    // Outside JTAG the TAP walks on zeros and leaves Test-Logic-Reset;
    // after the switch the tool must send three ones to get it back from Run-Test/Idle
    assign tap_bus.tms      = (mode == DPS_MODE_JTAG) ? data_bit : 1'b0;
    assign tap_bus.tdi      = aux_bit;

    dps_tap #(.IR_WIDTH(IR_WIDTH)) u_tap (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .tap_port   (tap_bus)
    );

    // Answer bit goes on the data pin in two-pin mode, on the separate pin in three-pin mode
    wire logic ack_on = (rx_state == DPS_RX_ACK);

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dbg_data_out               <= 1'b0;
            dbg_data_oe_out            <= 1'b0;
            dbg_tdo_out                <= 1'b0;
            dbg_tdo_oe_out             <= 1'b0;
            telegram_ok_out            <= 1'b0;
            crc_error_out              <= 1'b0;
            tap_in_reset_out           <= 1'b1;
            jtag_ir_out                <= IR_WIDTH'(`DPS_IR_RESET);
            protocol_mode_out          <= DPS_MODE_TWO_PIN;
            jtag_switch_guard_mode_out <= `DPS_GUARD_RESET;
        end else begin
            dbg_data_out               <= ack_val;
            dbg_data_oe_out            <= ack_on && (mode == DPS_MODE_TWO_PIN);
            dbg_tdo_out                <= (mode == DPS_MODE_JTAG) ? tap_bus.tdo : ack_val;
            dbg_tdo_oe_out             <= (mode == DPS_MODE_JTAG) || (ack_on && mode == DPS_MODE_THREE_PIN);
            telegram_ok_out            <= frame_ok;
            crc_error_out              <= crc_bad;
            tap_in_reset_out           <= tap_bus.in_reset;
            jtag_ir_out                <= tap_bus.ir;
            protocol_mode_out          <= mode;
            jtag_switch_guard_mode_out <= guard;
        end
    end

endmodule : dps_port

`default_nettype wire

// ===== rtl/dps_cfg.svh
// Constants of the debug port protocol select block: opcodes, CRC, guard codes, TAP values.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

`define DPS_FRAME_BITS      5'h18
`define DPS_OPC_JTAG        8'hA5
`define DPS_OPC_GUARD       8'h3C
`define DPS_OPC_THREE_PIN   8'h5A
`define DPS_CRC_POLY        8'h07
`define DPS_CRC_INIT        8'hFF
`define DPS_GUARD_RESET     2'h0
`define DPS_GUARD_PROTECT   2'h1
`define DPS_GUARD_THREE_PIN 2'h3
`define DPS_IR_CAPTURE      8'h01
`define DPS_IR_RESET        8'hFF

`endif

// ===== rtl/dps_pkg.sv
// Types shared by the debug port protocol select modules.
// Assumes dps_cfg.svh holds all numeric constants.
package dps_pkg;

    typedef enum logic [2:0] {
        DPS_MODE_TWO_PIN   = 3'h1,
        DPS_MODE_THREE_PIN = 3'h2,
        DPS_MODE_JTAG      = 3'h4
    } dps_mode_t;

    typedef enum logic [2:0] {
        DPS_RX_IDLE = 3'h1,
        DPS_RX_BITS = 3'h2,
        DPS_RX_ACK  = 3'h4
    } dps_rx_t;

    typedef enum logic [15:0] {
        DPS_TAP_TLR   = 16'h0001,
        DPS_TAP_RTI   = 16'h0002,
        DPS_TAP_SELDR = 16'h0004,
        DPS_TAP_CAPDR = 16'h0008,
        DPS_TAP_SHDR  = 16'h0010,
        DPS_TAP_EX1DR = 16'h0020,
        DPS_TAP_PADR  = 16'h0040,
        DPS_TAP_EX2DR = 16'h0080,
        DPS_TAP_UPDR  = 16'h0100,
        DPS_TAP_SELIR = 16'h0200,
        DPS_TAP_CAPIR = 16'h0400,
        DPS_TAP_SHIR  = 16'h0800,
        DPS_TAP_EX1IR = 16'h1000,
        DPS_TAP_PAIR  = 16'h2000,
        DPS_TAP_EX2IR = 16'h4000,
        DPS_TAP_UPIR  = 16'h8000
    } dps_tap_state_t;

endpackage : dps_pkg

// ===== rtl/dps_tap_if.sv
// Carrier between the port front end and the test access port controller.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface dps_tap_if #(parameter int IR_WIDTH = 8);
    logic                step;
    logic                tck_fall;
    logic                tms;
    logic                tdi;
    logic                tdo;
    logic                in_reset;
    logic [IR_WIDTH-1:0] ir;

    modport ctrl (output step, output tck_fall, output tms, output tdi,
                  input tdo, input in_reset, input ir);
    modport tap  (input step, input tck_fall, input tms, input tdi,
                  output tdo, output in_reset, output ir);
endinterface : dps_tap_if

`default_nettype wire

// ===== rtl/dps_tap.sv
// Test access port controller stepped by port clock edge pulses.
// Assumes step and tck_fall are one-cycle pulses from the front end.
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module dps_tap #(
    parameter int IR_WIDTH = 8
) (
    input  wire logic ref_clk_in,
    input  wire logic reset_n_in,
    dps_tap_if.tap    tap_port
);
    import dps_pkg::*;

    if (IR_WIDTH < 2) begin : g_bad_width
        $error("dps_tap: IR_WIDTH must be at least 2");
    end

    dps_tap_state_t      state;
    dps_tap_state_t      next_state;
    logic [IR_WIDTH-1:0] ir_shift;
    logic [IR_WIDTH-1:0] ir;
    logic                bypass;
    logic                tdo;

    function automatic dps_tap_state_t tap_next(input dps_tap_state_t s, input logic tms);
        case (s)
            DPS_TAP_TLR:   tap_next = tms ? DPS_TAP_TLR   : DPS_TAP_RTI;
            DPS_TAP_RTI:   tap_next = tms ? DPS_TAP_SELDR : DPS_TAP_RTI;
            DPS_TAP_SELDR: tap_next = tms ? DPS_TAP_SELIR : DPS_TAP_CAPDR;
            DPS_TAP_CAPDR: tap_next = tms ? DPS_TAP_EX1DR : DPS_TAP_SHDR;
            DPS_TAP_SHDR:  tap_next = tms ? DPS_TAP_EX1DR : DPS_TAP_SHDR;
            DPS_TAP_EX1DR: tap_next = tms ? DPS_TAP_UPDR  : DPS_TAP_PADR;
            DPS_TAP_PADR:  tap_next = tms ? DPS_TAP_EX2DR : DPS_TAP_PADR;
            DPS_TAP_EX2DR: tap_next = tms ? DPS_TAP_UPDR  : DPS_TAP_SHDR;
            DPS_TAP_UPDR:  tap_next = tms ? DPS_TAP_SELDR : DPS_TAP_RTI;
            DPS_TAP_SELIR: tap_next = tms ? DPS_TAP_TLR   : DPS_TAP_CAPIR;
            DPS_TAP_CAPIR: tap_next = tms ? DPS_TAP_EX1IR : DPS_TAP_SHIR;
            DPS_TAP_SHIR:  tap_next = tms ? DPS_TAP_EX1IR : DPS_TAP_SHIR;
            DPS_TAP_EX1IR: tap_next = tms ? DPS_TAP_UPIR  : DPS_TAP_PAIR;
            DPS_TAP_PAIR:  tap_next = tms ? DPS_TAP_EX2IR : DPS_TAP_PAIR;
            DPS_TAP_EX2IR: tap_next = tms ? DPS_TAP_UPIR  : DPS_TAP_SHIR;
            DPS_TAP_UPIR:  tap_next = tms ? DPS_TAP_SELDR : DPS_TAP_RTI;
            default:       tap_next = DPS_TAP_TLR;
        endcase
    endfunction : tap_next

    assign next_state = tap_next(state, tap_port.tms);

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= DPS_TAP_TLR;
        end else if (tap_port.step) begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ir_shift <= '0;
            ir       <= IR_WIDTH'(`DPS_IR_RESET);
            bypass   <= 1'b0;
        end else if (tap_port.step) begin
            if (next_state == DPS_TAP_CAPIR) begin
                ir_shift <= IR_WIDTH'(`DPS_IR_CAPTURE);
            end else if (state == DPS_TAP_SHIR) begin
                ir_shift <= {tap_port.tdi, ir_shift[IR_WIDTH-1:1]};
            end
            // Copy happens even with zero bits shifted: host must shift a full word
            if (next_state == DPS_TAP_UPIR) begin
                ir <= ir_shift;
            end else if (next_state == DPS_TAP_TLR) begin
                ir <= IR_WIDTH'(`DPS_IR_RESET);
            end
            if (next_state == DPS_TAP_CAPDR) begin
                bypass <= 1'b0;
            end else if (state == DPS_TAP_SHDR) begin
                bypass <= tap_port.tdi;
            end
        end
    end

    // Output changes on the falling port clock so the host samples a settled bit
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tdo <= 1'b0;
        end else if (tap_port.tck_fall) begin
            tdo <= (state == DPS_TAP_SHIR) ? ir_shift[0] : ((state == DPS_TAP_SHDR) ? bypass : 1'b0);
        end
    end

    assign tap_port.tdo      = tdo;
    assign tap_port.ir       = ir;
    assign tap_port.in_reset = (state == DPS_TAP_TLR);

endmodule : dps_tap

`default_nettype wire

// ===== bench/dps_port_checker.sv
// Port-level checks of the protocol select front end.
// Assumes one system clock domain; bound to dps_port at the foot.
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module dps_port_checker #(
    parameter int IR_WIDTH = 8
) (
    input wire logic                ref_clk_in,
    input wire logic                reset_n_in,
    input wire logic                dbg_data_out,
    input wire logic                dbg_data_oe_out,
    input wire dps_pkg::dps_mode_t  protocol_mode_out,
    input wire logic [1:0]          jtag_switch_guard_mode_out,
    input wire logic                telegram_ok_out,
    input wire logic                crc_error_out,
    input wire logic                tap_in_reset_out,
    input wire logic [IR_WIDTH-1:0] jtag_ir_out
);
    import dps_pkg::*;
    logic [1:0] guard;
    dps_mode_t  mode;
    assign guard = jtag_switch_guard_mode_out;
    assign mode  = protocol_mode_out;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    chk_pulse_apart: assert property (!(telegram_ok_out && crc_error_out))
        else $error("ok and crc error pulses together");
    chk_ok_single: assert property (telegram_ok_out |=> !telegram_ok_out)
        else $error("ok pulse longer than one cycle");
    // The mode and guard outputs trail the accept pulse by one cycle
    chk_three_cause: assert property ($changed(mode) && mode == DPS_MODE_THREE_PIN |-> $past(telegram_ok_out))
        else $error("three-pin mode without accepted telegram");
    chk_guard_cause: assert property ($changed(guard) |-> $past(telegram_ok_out))
        else $error("guard changed without accepted telegram");
    chk_guard_protect: assert property (guard == `DPS_GUARD_PROTECT && mode != DPS_MODE_JTAG |=> mode != DPS_MODE_JTAG)
        else $error("jtag switch taken under protecting guard");
    chk_guard_three: assert property ($changed(guard) && guard == `DPS_GUARD_THREE_PIN |-> ##[0:2] mode == DPS_MODE_THREE_PIN)
        else $error("guard 11 without three-pin mode");
    chk_tlr_jtag_only: assert property ($rose(tap_in_reset_out) |-> mode == DPS_MODE_JTAG)
        else $error("tap reached reset outside jtag mode");
    chk_tlr_ir: assert property (tap_in_reset_out [*2] |-> jtag_ir_out == IR_WIDTH'(`DPS_IR_RESET))
        else $error("instruction not all ones in tap reset");
    // The answer pin follows the mode the telegram itself selects
    chk_ack_good: assert property (telegram_ok_out ##1 mode == DPS_MODE_TWO_PIN |-> dbg_data_oe_out && dbg_data_out)
        else $error("accepted telegram not answered with 1");
    chk_ack_bad: assert property (crc_error_out && mode == DPS_MODE_TWO_PIN |-> ##[0:2] (dbg_data_oe_out && !dbg_data_out))
        else $error("crc failure not answered with 0");

    cov_three: cover property ($rose(mode == DPS_MODE_THREE_PIN));
    cov_jtag: cover property ($rose(mode == DPS_MODE_JTAG));
    cov_crc: cover property (crc_error_out);
endmodule : dps_port_checker

bind dps_port dps_port_checker #(.IR_WIDTH(IR_WIDTH)) u_chk (.ref_clk_in, .reset_n_in, .dbg_data_out,
    .dbg_data_oe_out, .protocol_mode_out, .jtag_switch_guard_mode_out, .telegram_ok_out, .crc_error_out,
    .tap_in_reset_out, .jtag_ir_out);

`default_nettype wire

// ===== bench/dps_tool.sv
// Behavioural model of the external debug tool on the port pins.
// Assumes the bench resolves the shared data pin with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module dps_tool (
    output logic      port_clk_out,
    output logic      data_out,
    output logic      data_oe_out,
    output logic      aux_out,
    input  wire logic pin_in,
    input  wire logic tdo_in,
    input  wire logic tdo_oe_in
);
    // Port clock stands still low between frames and ticks
    initial begin
        port_clk_out = 1'b0;
        data_out     = 1'b1;
        data_oe_out  = 1'b1;
        aux_out      = 1'b0;
    end

    // Start bit then 24 bits MSB first, then one answer clock
    task automatic frame(input logic [23:0] bits, output logic ack);
        logic [24:0] f;
        f = {1'b0, bits};
        #1.3;
        for (int i = 24; i >= 0; i--) begin
            data_out = f[i];
            #80 port_clk_out = 1'b1;
            #80 port_clk_out = 1'b0;
        end
        data_oe_out = 1'b0;
        #70 ack = tdo_oe_in ? tdo_in : pin_in;
        #10 port_clk_out = 1'b1;
        #80 port_clk_out = 1'b0;
        data_out = 1'b1;
        data_oe_out = 1'b1;
    endtask : frame

    // Odd offset keeps port edges off the system clock edges
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        #1.3;
        data_out = tms;
        aux_out = tdi;
        #70 tdo = tdo_in;
        #10 port_clk_out = 1'b1;
        #80 port_clk_out = 1'b0;
    endtask : tick
endmodule : dps_tool

`default_nettype wire

// ===== bench/debug_port_protocol_select_test.sv
// Self-checking bench for the protocol select front end.
// Assumes the tool model drives the port pins with delays of its own.
`timescale 1ns/1ps
`default_nettype none
`include "dps_cfg.svh"

module debug_port_protocol_select_test;
    import dps_pkg::*;
    logic       ref_clk_in;
    logic       reset_n_in;
    logic       restart_in;
    logic       tool_clk;
    logic       tool_d;
    logic       tool_oe;
    logic       tool_aux;
    wire logic  data_pin;
    logic       d_out;
    logic       d_oe;
    logic       tdo;
    logic       tdo_oe;
    dps_mode_t  mode;
    logic [1:0] guard;
    logic       ok_p;
    logic       crc_p;
    logic       tlr;
    logic [7:0] ir;
    int         errors;
    int         checks;
    int         ok_n;
    int         crc_n;

    assign data_pin = d_oe ? d_out : (tool_oe ? tool_d : 1'b1);

    dps_port i_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .debug_port_clock_pin_in(tool_clk),
        .dbg_data_in(data_pin), .dbg_data_out(d_out), .dbg_data_oe_out(d_oe), .dbg_aux_in(tool_aux),
        .dbg_tdo_out(tdo), .dbg_tdo_oe_out(tdo_oe), .restart_in(restart_in), .protocol_mode_out(mode),
        .jtag_switch_guard_mode_out(guard), .telegram_ok_out(ok_p), .crc_error_out(crc_p),
        .tap_in_reset_out(tlr), .jtag_ir_out(ir));
    dps_tool i_tool (.port_clk_out(tool_clk), .data_out(tool_d), .data_oe_out(tool_oe), .aux_out(tool_aux),
        .pin_in(data_pin), .tdo_in(tdo), .tdo_oe_in(tdo_oe));

    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in) begin
        ok_n  <= ok_n + int'(ok_p === 1'b1);
        crc_n <= crc_n + int'(crc_p === 1'b1);
    end

    task automatic cmp_v8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_v8

    task automatic cmp_mode(input dps_mode_t got, input dps_mode_t exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: mode %h expected %h", $time, got, exp);
        end
    endtask : cmp_mode

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = `DPS_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `DPS_CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8

    // A wrong checksum is made by flipping a fixed bit pattern
    task automatic tg(input logic [7:0] opc, input logic [7:0] arg, input logic good, output logic ack);
        i_tool.frame({opc, arg, crc8({opc, arg}) ^ (good ? 8'h00 : 8'h5A)}, ack);
    endtask : tg

    task automatic seq(input logic [7:0] b, input int n);
        logic t;
        for (int i = 0; i < n; i++) begin
            i_tool.tick(b[i], 1'b0, t);
        end
    endtask : seq

    task automatic t_link;
        logic a;
        cmp_mode(mode, DPS_MODE_TWO_PIN);
        cmp_v8({6'h00, guard}, {6'h00, `DPS_GUARD_RESET});
        cmp_v8(ir, `DPS_IR_RESET);
        tg(`DPS_OPC_GUARD, 8'h01, 1'b0, a);
        cmp_v8({7'h00, a}, 8'h00);
        cmp_v8(8'(crc_n), 8'h01);
        cmp_v8({6'h00, guard}, 8'h00);
        cmp_v8({7'h00, tlr}, 8'h00);
        tg(8'h11, 8'h00, 1'b1, a);
        cmp_v8({7'h00, a}, 8'h00);
        tg(`DPS_OPC_GUARD, 8'h01, 1'b1, a);
        cmp_v8({7'h00, a}, 8'h01);
        cmp_v8({6'h00, guard}, {6'h00, `DPS_GUARD_PROTECT});
        tg(`DPS_OPC_JTAG, 8'h00, 1'b0, a);
        cmp_v8({7'h00, a}, 8'h00);
        cmp_mode(mode, DPS_MODE_TWO_PIN);
        cmp_v8(8'(ok_n), 8'h01);
        tg(`DPS_OPC_THREE_PIN, 8'h00, 1'b1, a);
        cmp_mode(mode, DPS_MODE_THREE_PIN);
        cmp_v8({7'h00, a}, 8'h01);
        tg(`DPS_OPC_GUARD, 8'h03, 1'b1, a);
        cmp_v8({7'h00, a}, 8'h01);
        cmp_v8({6'h00, guard}, {6'h00, `DPS_GUARD_THREE_PIN});
        tg(`DPS_OPC_JTAG, 8'h00, 1'b0, a);
        cmp_mode(mode, DPS_MODE_JTAG);
        $display("t_link done");
    endtask : t_link

    task automatic t_jtag;
        logic       t;
        logic [7:0] v;
        logic [7:0] w;
        v = 8'h00;
        w = 8'hC3;
        seq(8'hFF, 8);
        seq(8'hFF, 2);
        cmp_v8({7'h00, tlr}, 8'h01);
        seq(8'h06, 5);
        for (int i = 0; i < 8; i++) begin
            i_tool.tick(i == 7, w[i], t);
            v = {t, v[7:1]};
        end
        seq(8'h01, 2);
        cmp_v8(v, `DPS_IR_CAPTURE);
        cmp_v8(ir, w);
        seq(8'h1B, 6);
        cmp_v8(ir, `DPS_IR_CAPTURE);
        $display("t_jtag done");
    endtask : t_jtag

    task automatic t_restart;
        logic t;
        @(posedge ref_clk_in);
        restart_in <= 1'b1;
        repeat (40) @(posedge ref_clk_in);
        cmp_mode(mode, DPS_MODE_JTAG);
        i_tool.tick(1'b1, 1'b0, t);
        @(posedge ref_clk_in);
        restart_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        cmp_mode(mode, DPS_MODE_TWO_PIN);
        $display("t_restart done");
    endtask : t_restart

    initial begin
        reset_n_in = 1'b0;
        restart_in = 1'b0;
        errors = 0;
        checks = 0;
        ok_n = 0;
        crc_n = 0;
        repeat (6) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        t_link;
        t_jtag;
        t_restart;
        print_verdict;
    end

    initial begin
        repeat (30000) @(posedge ref_clk_in);
        errors++;
        $display("mismatch at %0t: run timed out", $time);
        print_verdict;
    end
endmodule : debug_port_protocol_select_test

`default_nettype wire
